// ==== design/cie_pkg.sv ====
// package for the instruction execution subset: register map, opcode layout, states
// assumes a single 125 MHz core clock and an apb master on the register side
package cie_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_BANK = 8'h0c;
    localparam logic [7:0] OFF_UPJ = 8'h10;
    localparam logic [7:0] OFF_PC = 8'h14;
    localparam logic [7:0] OFF_PTR0 = 8'h18;
    localparam logic [7:0] OFF_PTR1 = 8'h1c;
    localparam logic [7:0] OFF_MEM_ADDR = 8'h20;
    localparam logic [7:0] OFF_MEM_DATA = 8'h24;

    // status fields
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;

    // reset values
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [5:0] RST_BANK = 6'h00;
    localparam logic [6:0] RST_UPJ = 7'h00;
    localparam logic [15:0] RST_PTR = 16'h0000;

    // ----------------------------------------------------------------
    // instruction word: 4-bit class, 10-bit argument
    // ----------------------------------------------------------------
    localparam int INSTR_W = 14;
    localparam logic [3:0] OPC_NOP = 4'h0;
    localparam logic [3:0] OPC_BRANCH_BY_ACC = 4'h1;
    localparam logic [3:0] OPC_BIT_SET = 4'h2;
    localparam logic [3:0] OPC_IND_LOAD_STEP = 4'h3;
    localparam logic [3:0] OPC_IND_LOAD_OFS = 4'h4;
    localparam logic [3:0] OPC_LOAD_BANK = 4'h5;
    localparam logic [3:0] OPC_LOAD_UPPER = 4'h6;
    localparam logic [3:0] OPC_LOAD_ACC = 4'h7;
    localparam logic [3:0] OPC_STORE_ACC = 4'h8;

    // pointer_update_code encodings
    localparam logic [1:0] PUC_PRE_INC = 2'b00;
    localparam logic [1:0] PUC_PRE_DEC = 2'b01;
    localparam logic [1:0] PUC_POST_INC = 2'b10;
    localparam logic [1:0] PUC_POST_DEC = 2'b11;

    // file addresses that open the indirect windows
    localparam logic [6:0] IND_WIN0 = 7'h00;
    localparam logic [6:0] IND_WIN1 = 7'h01;

    typedef struct packed {
        logic [3:0] op;
        logic [9:0] arg;
    } cie_instr_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BRANCH = 2'b01
    } cie_state_e;

endpackage

// ==== design/cie_core.sv ====
// execution unit for a subset of an 8-bit core: branch by accumulator, bit set,
// indirect load, literal loads and accumulator store, issued over apb
// assumes one apb master on pclk; the data memory lives inside this module
//
// Summary of operation
// RULE1: branch adds unsigned accumulator to incremented pc
// RULE2: bit set forces one bit, others kept
// RULE3: indirect load copies pointed byte into accumulator
// RULE4: update code selects pre/post increment/decrement
// RULE5: pre modes address stepped pointer, post old
// RULE6: offset form adds signed literal, pointer unchanged
// RULE7: indirect windows map to pointed data location
// RULE8: pointers wrap modulo sixteen bits
// RULE9: bank literal loads six-bit bank pointer
// RULE10: upper literal loads seven-bit jump latch
// RULE11: accumulator literal load, one cycle
// RULE12: accumulator store to file register, one cycle
// RULE13: zero flag set when loaded byte is zero
`timescale 1ns/1ps

module cie_core
    import cie_pkg::*;
#(
    parameter int MEM_AW = 13,
    parameter int PC_W = 15
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cie_state_e state_q;
    logic [7:0] acc_q;
    logic zero_q;
    logic [5:0] bank_q;
    logic [6:0] upj_q;
    logic [PC_W-1:0] pc_q;
    logic [15:0] ptr_q [2];
    logic [15:0] mem_addr_q;
    logic [13:0] last_instr_q;
    logic [31:0] prdata_q;
    logic cap_q;
    logic [7:0] mem [1 << MEM_AW];

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic access;
    logic wr_done;
    logic mapped;
    logic issue;
    cie_instr_s instr;

    always_comb
    begin
        case (paddr)
            OFF_INSTR, OFF_ACC, OFF_STATUS, OFF_BANK, OFF_UPJ, OFF_PC,
            OFF_PTR0, OFF_PTR1, OFF_MEM_ADDR, OFF_MEM_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // a read is answered only after a capture taken while idle, so the value
    // never predates the second cycle of a branch
    assign access = psel && penable;
    assign pready = access && cap_q && (state_q == ST_IDLE);
    assign pslverr = pready && !mapped;
    assign prdata = prdata_q;
    assign wr_done = pready && pwrite && mapped;
    assign issue = wr_done && (paddr == OFF_INSTR);
    assign instr = cie_instr_s'(pwdata[INSTR_W-1:0]);

    // ----------------------------------------------------------------
    // operand decode
    // ----------------------------------------------------------------
    logic [6:0] f_addr;
    logic [2:0] bit_idx;
    logic ptr_n;
    logic [1:0] puc;
    logic [5:0] ofs_k;
    logic [15:0] ptr_cur;
    logic [15:0] ptr_step;
    logic [15:0] ea;
    logic [MEM_AW-1:0] file_loc;
    logic [7:0] load_byte;
    logic is_step;
    logic is_ofs;

    assign f_addr = instr.arg[6:0];
    assign bit_idx = instr.arg[9:7];
    assign is_step = instr.op == OPC_IND_LOAD_STEP;
    assign is_ofs = instr.op == OPC_IND_LOAD_OFS;
    assign ptr_n = is_ofs ? instr.arg[6] : instr.arg[2];
    assign puc = instr.arg[1:0];
    assign ofs_k = instr.arg[5:0];
    assign ptr_cur = ptr_q[ptr_n];

    // low bit of the code picks the direction, high bit pre or post
    always_comb
    begin
        if (puc == PUC_PRE_DEC || puc == PUC_POST_DEC)
        begin
            ptr_step = ptr_cur - 16'h0001; // RULE8
        end
        else
        begin
            ptr_step = ptr_cur + 16'h0001; // RULE8
        end
    end

    always_comb
    begin
        if (is_ofs)
        begin
            ea = ptr_cur + {{10{ofs_k[5]}}, ofs_k}; // RULE6
        end
        else if (puc == PUC_PRE_INC || puc == PUC_PRE_DEC)
        begin
            ea = ptr_step; // RULE5
        end
        else
        begin
            ea = ptr_cur; // RULE5
        end
    end

    // file operand: the two window addresses have no storage and follow a pointer
    always_comb
    begin
        logic [15:0] lin;
        lin = {3'h0, bank_q, f_addr};
        if (f_addr == IND_WIN0)
        begin
            lin = ptr_q[0]; // RULE7
        end
        else if (f_addr == IND_WIN1)
        begin
            lin = ptr_q[1]; // RULE7
        end
        file_loc = lin[MEM_AW-1:0];
    end

    assign load_byte = mem[ea[MEM_AW-1:0]]; // RULE3

    // ----------------------------------------------------------------
    // sequencing and program counter
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (issue && instr.op == OPC_BRANCH_BY_ACC)
                    begin
                        state_q <= ST_BRANCH; // RULE1
                    end
                end
                ST_BRANCH: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // every issue steps the pc once; a branch adds the accumulator a cycle later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_q <= '0;
        end
        else if (state_q == ST_BRANCH)
        begin
            pc_q <= pc_q + PC_W'(acc_q); // RULE1
        end
        else if (issue)
        begin
            pc_q <= pc_q + PC_W'(1);
        end
        else if (wr_done && paddr == OFF_PC)
        begin
            pc_q <= pwdata[PC_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // accumulator and zero flag
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q <= RST_ACC;
        end
        else if (issue && (is_step || is_ofs))
        begin
            acc_q <= load_byte; // RULE3
        end
        else if (issue && instr.op == OPC_LOAD_ACC)
        begin
            acc_q <= instr.arg[7:0]; // RULE11
        end
        else if (wr_done && paddr == OFF_ACC)
        begin
            acc_q <= pwdata[7:0];
        end
    end

    // only the indirect load touches the flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zero_q <= 1'b0;
        end
        else if (issue && (is_step || is_ofs))
        begin
            zero_q <= (load_byte == 8'h00); // RULE13
        end
    end

    // ----------------------------------------------------------------
    // bank pointer and upper jump latch
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bank_q <= RST_BANK;
        end
        else if (issue && instr.op == OPC_LOAD_BANK)
        begin
            bank_q <= instr.arg[5:0]; // RULE9
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            upj_q <= RST_UPJ;
        end
        else if (issue && instr.op == OPC_LOAD_UPPER)
        begin
            upj_q <= instr.arg[6:0]; // RULE10
        end
    end

    // ----------------------------------------------------------------
    // indirect pointers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr_q[0] <= RST_PTR;
            ptr_q[1] <= RST_PTR;
        end
        else if (issue && is_step)
        begin
            ptr_q[ptr_n] <= ptr_step; // RULE4
        end
        else if (wr_done && paddr == OFF_PTR0)
        begin
            ptr_q[0] <= pwdata[15:0];
        end
        else if (wr_done && paddr == OFF_PTR1)
        begin
            ptr_q[1] <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // data memory
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_addr_q <= 16'h0000;
        end
        else if (wr_done && paddr == OFF_MEM_ADDR)
        begin
            mem_addr_q <= pwdata[15:0];
        end
    end

    // no reset on the array: contents are undefined until written
    always_ff @(posedge pclk)
    begin
        if (issue && instr.op == OPC_BIT_SET)
        begin
            mem[file_loc][bit_idx] <= 1'b1; // RULE2
        end
        else if (issue && instr.op == OPC_STORE_ACC)
        begin
            mem[file_loc] <= acc_q; // RULE12
        end
        else if (wr_done && paddr == OFF_MEM_DATA)
        begin
            mem[mem_addr_q[MEM_AW-1:0]] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_instr_q <= '0;
        end
        else if (issue)
        begin
            last_instr_q <= pwdata[INSTR_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFF_INSTR: rd_mux = {18'h0, last_instr_q};
            OFF_ACC: rd_mux = {24'h0, acc_q};
            OFF_STATUS:
            begin
                rd_mux[STAT_ZERO_BIT] = zero_q;
                rd_mux[STAT_BUSY_BIT] = (state_q != ST_IDLE);
            end
            OFF_BANK: rd_mux = {26'h0, bank_q};
            OFF_UPJ: rd_mux = {25'h0, upj_q};
            OFF_PC: rd_mux = 32'(pc_q);
            OFF_PTR0: rd_mux = {16'h0, ptr_q[0]};
            OFF_PTR1: rd_mux = {16'h0, ptr_q[1]};
            OFF_MEM_ADDR: rd_mux = {16'h0, mem_addr_q};
            OFF_MEM_DATA: rd_mux = {24'h0, mem[mem_addr_q[MEM_AW-1:0]]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            cap_q <= 1'b0;
        end
        else
        begin
            prdata_q <= rd_mux;
            cap_q <= psel && (state_q == ST_IDLE);
        end
    end

endmodule

// ==== dv/cie_core_sva.sv ====
// assertions on the apb ports of cie_core
// assumes it is bound to cie_core and sees only its ports
`timescale 1ns/1ps
module cie_core_chk
    import cie_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic done, iss, rd, acc_ok_q;
    logic stat_ok_q, stat_z_q;
    logic [3:0] op;
    logic [7:0] acc_q;
    logic [5:0] bank_q;
    logic [6:0] upj_q;
    assign done = psel && penable && pready;
    assign iss = done && pwrite && paddr == OFF_INSTR;
    assign rd = done && !pwrite;
    assign op = pwdata[13:10];
    // ------
    // shadows of registers that only visible writes change
    // ------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q <= RST_ACC;
            acc_ok_q <= 1'b1;
            bank_q <= RST_BANK;
            upj_q <= RST_UPJ;
            stat_ok_q <= 1'b1;
            stat_z_q <= 1'b0;
        end
        else
        begin
            if ((done && pwrite && paddr == OFF_ACC) || (iss && op == OPC_LOAD_ACC))
            begin
                acc_q <= pwdata[7:0];
                acc_ok_q <= 1'b1;
            end
            else if (iss && (op == OPC_IND_LOAD_STEP || op == OPC_IND_LOAD_OFS))
                acc_ok_q <= 1'b0;  // memory byte is not seen here
            if (iss && op == OPC_LOAD_BANK)
                bank_q <= pwdata[5:0];
            if (iss && op == OPC_LOAD_UPPER)
                upj_q <= pwdata[6:0];
            // the flag is only known again after software has read it back
            if (iss && (op == OPC_IND_LOAD_STEP || op == OPC_IND_LOAD_OFS))
                stat_ok_q <= 1'b0;
            else if (rd && paddr == OFF_STATUS)
            begin
                stat_ok_q <= 1'b1;
                stat_z_q <= prdata[STAT_ZERO_BIT];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_acc; rd && paddr == OFF_ACC && acc_ok_q |-> prdata == {24'h0, acc_q}; endproperty
    a_acc: assert property (p_acc) else $error("acc read wrong");
    property p_bank; rd && paddr == OFF_BANK |-> prdata == {26'h0, bank_q}; endproperty
    a_bank: assert property (p_bank) else $error("bank read wrong");
    property p_upj; rd && paddr == OFF_UPJ |-> prdata == {25'h0, upj_q}; endproperty
    a_upj: assert property (p_upj) else $error("latch read wrong");
    property p_ptr; rd && (paddr == OFF_PTR0 || paddr == OFF_PTR1) |-> prdata[31:16] == 16'h0; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer too wide");
    property p_stat;
        rd && paddr == OFF_STATUS && stat_ok_q |-> prdata[STAT_ZERO_BIT] == stat_z_q && prdata[31:2] == 30'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("status flag changed without an indirect load");
    property p_brw; iss && op == OPC_BRANCH_BY_ACC ##1 (psel && !penable) |=> !pready ##1 pready; endproperty
    a_brw: assert property (p_brw) else $error("branch not two cycles");
    property p_one; iss && (op == OPC_LOAD_ACC || op == OPC_STORE_ACC) ##1 (psel && !penable) |=> pready; endproperty
    a_one: assert property (p_one) else $error("literal or store not one cycle");
    property p_err; pslverr |-> pready && !(paddr <= OFF_MEM_DATA && paddr[1:0] == 2'b00); endproperty
    a_err: assert property (p_err) else $error("error on mapped address");
    c_brw: cover property (iss && op == OPC_BRANCH_BY_ACC);
    c_ind: cover property (iss && op == OPC_IND_LOAD_STEP);
    c_err: cover property (pslverr);
endmodule
bind cie_core cie_core_chk cie_core_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ==== dv/cie_apb_master.sv ====
// apb master model standing in for the fetch side
// assumes one caller at a time; the result is taken at the ready edge
`timescale 1ns/1ps
module cie_apb_master
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic held = 1'b0;
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // keep leaves psel up so the next setup follows the access at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep,
                        output logic [31:0] r, output logic e, output logic to);
        int n;
        n = 0;
        to = 1'b1;
        {r, e} = '0;
        if (!held)
            @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        while (to && n < 64)
        begin
            // read before this edge's updates land, so these are the values the edge takes
            @(posedge pclk);
            n++;
            if (pready === 1'b1)
            begin
                {r, e, to} = {prdata, pslverr, 1'b0};
            end
        end
        held = keep && !to;
        if (!held)
            {psel, penable, pwdata} <= {2'b00, ~d};
    endtask
endmodule

// ==== dv/cie_core_tb.sv ====
// self-checking bench for cie_core driven by the apb master model
// assumes the checker is bound to cie_core
`timescale 1ns/1ps
module cie_core_tb
    import cie_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int err_count, n_tests;
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    cie_core #(.MEM_AW(13), .PC_W(15)) cie_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cie_apb_master cie_apb_master_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ------
    // shared tasks
    // ------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x)
        begin
            err_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic k,
                       output logic [31:0] r, output logic e);
        logic to;
        cie_apb_master_i.xfer(w, a, d, k, r, e, to);
        if (to)
        begin
            chk(32'h0, 32'h1);
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic k = 1'b0);
        logic [31:0] r;
        logic e;
        bus(1'b1, a, d, k, r, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        bus(1'b0, a, 32'h0, 1'b0, r, e);
        chk(r, x);
    endtask
    task automatic ex(input logic [3:0] op, input logic [9:0] arg, input logic k = 1'b0);
        wr(OFF_INSTR, {18'h0, op, arg}, k);
    endtask
    task automatic mw(input logic [15:0] a, input logic [7:0] d);
        wr(OFF_MEM_ADDR, {16'h0, a});
        wr(OFF_MEM_DATA, {24'h0, d});
    endtask
    // ------
    // scenarios
    // ------
    task automatic t_reset();
        logic [7:0] offs [7] = '{OFF_ACC, OFF_STATUS, OFF_BANK, OFF_UPJ, OFF_PC, OFF_PTR0, OFF_PTR1};
        logic [31:0] r;
        logic e;
        foreach (offs[i])
            rdc(offs[i], 32'h0);
        bus(1'b0, 8'h28, 32'h0, 1'b0, r, e);
        chk({r[30:0], e}, 32'h1);
        bus(1'b1, 8'h40, 32'h0, 1'b0, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_indirect();
        logic [15:0] eptr [4] = '{16'h0101, 16'h00ff, 16'h0101, 16'h00ff};
        logic [7:0] edat [4] = '{8'h22, 8'h33, 8'h11, 8'h11};
        mw(16'h0100, 8'h11);
        mw(16'h0101, 8'h22);
        mw(16'h00ff, 8'h33);
        mw(16'h013f, 8'h44);
        mw(16'h1fff, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_PTR1, 32'h0100);
            ex(OPC_IND_LOAD_STEP, {7'h0, 1'b1, i[1:0]});
            rdc(OFF_ACC, {24'h0, edat[i]});
            rdc(OFF_PTR1, {16'h0, eptr[i]});
            rdc(OFF_STATUS, 32'h0);
        end
        wr(OFF_PTR0, 32'h0120);
        ex(OPC_IND_LOAD_OFS, 10'h020);
        rdc(OFF_ACC, 32'h11);
        ex(OPC_IND_LOAD_OFS, 10'h01f);
        rdc(OFF_ACC, 32'h44);
        rdc(OFF_PTR0, 32'h0120);
        wr(OFF_PTR0, 32'hffff);
        ex(OPC_IND_LOAD_STEP, 10'h002);
        rdc(OFF_PTR0, 32'h0);
        rdc(OFF_STATUS, 32'h1);
        ex(OPC_IND_LOAD_STEP, 10'h001);
        rdc(OFF_PTR0, 32'hffff);
        $display("test indirect done");
    endtask
    task automatic t_literals();
        ex(OPC_LOAD_BANK, 10'h3ff);
        ex(OPC_LOAD_UPPER, 10'h3ff);
        ex(OPC_LOAD_ACC, 10'h3a5, 1'b1);
        rdc(OFF_ACC, 32'ha5);
        rdc(OFF_BANK, 32'h3f);
        rdc(OFF_UPJ, 32'h7f);
        rdc(OFF_STATUS, 32'h1);
        $display("test literals done");
    endtask
    task automatic t_store_bits();
        logic [7:0] m = 8'h00;
        ex(OPC_LOAD_BANK, 10'h002);
        ex(OPC_LOAD_ACC, 10'h000);
        ex(OPC_STORE_ACC, 10'h07f);
        wr(OFF_MEM_ADDR, 32'h017f);
        for (int b = 0; b < 8; b++)
        begin
            m[b] = 1'b1;
            ex(OPC_BIT_SET, {b[2:0], 7'h7f});
            rdc(OFF_MEM_DATA, {24'h0, m});
        end
        ex(OPC_LOAD_ACC, 10'h04f);
        ex(OPC_STORE_ACC, 10'h07f, 1'b1);
        rdc(OFF_MEM_DATA, 32'h4f);
        ex(OPC_LOAD_BANK, 10'h000);
        wr(OFF_PTR1, 32'h0200);
        ex(OPC_STORE_ACC, {3'h0, IND_WIN1});
        wr(OFF_MEM_ADDR, 32'h0200);
        rdc(OFF_MEM_ADDR, 32'h0200);
        rdc(OFF_MEM_DATA, 32'h4f);
        rdc(OFF_STATUS, 32'h1);
        $display("test store and bit set done");
    endtask
    task automatic t_branch();
        wr(OFF_PC, 32'h0010);
        wr(OFF_ACC, 32'h00f0);
        ex(OPC_BRANCH_BY_ACC, 10'h000, 1'b1);
        rdc(OFF_PC, 32'h0101);
        rdc(OFF_STATUS, 32'h1);
        ex(OPC_NOP, 10'h3ff);
        rdc(OFF_PC, 32'h0102);
        rdc(OFF_INSTR, {18'h0, OPC_NOP, 10'h3ff});
        rdc(OFF_ACC, 32'hf0);
        $display("test branch done");
    endtask
    initial
    begin
        err_count = 0;
        n_tests = 0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_indirect();
        t_literals();
        t_store_bits();
        t_branch();
        complete_run();
    end
endmodule
